//--- hdl/wdt_pkg.sv
// Package: constants for the watchdog and interval timer.
// Assumes a single 100 MHz core clock that also serves as peripheral clock.
package wdt_pkg;
	localparam int CLK_MHZ = 100;
	localparam logic [3:0] ADDR_COUNTER = 4'h0;
	localparam logic [3:0] ADDR_CTRL = 4'h4;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;
	localparam logic [7:0] KEY_COUNTER = 8'h5A;
	localparam logic [7:0] KEY_CTRL = 8'hA5;
	localparam int BIT_RUN = 7;
	localparam int BIT_MODE = 6;
	localparam int BIT_RST_KIND = 5;
	localparam int BIT_WD_OVF = 4;
	localparam int BIT_IT_OVF = 3;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_FLAG_MASK = 8'h18;
	localparam logic [7:0] COUNT_MAX = 8'hFF;
	localparam int PRESCALE_W = 12;
	localparam int MANUAL_PULSE_CYCLES = 5;
	localparam int IRQ_WD = 0;
	localparam int IRQ_IT = 1;
	localparam logic [1:0] IRQ_ZERO = 2'h0;
endpackage

//--- hdl/wdt_tick_if.sv
// Interface: count tick passed from the prescaler to the timer core.
// Assumes both ends share the core clock.
`timescale 1ns/1ps
interface wdt_tick_if;
	logic run;
	logic [2:0] sel;
	logic tick;
	modport src (input run, input sel, output tick);
	modport dst (output run, output sel, input tick);
endinterface // wdt_tick_if

//--- hdl/wdt_prescaler.sv
// Prescaler: one-cycle count enable at the selected division ratio.
// Assumes the select is steady while the timer runs.
`timescale 1ns/1ps
module wdt_prescaler (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// Tick
	wdt_tick_if.src tk
);
	import wdt_pkg::*;
	logic [PRESCALE_W-1:0] pre_reg;
	logic [PRESCALE_W-1:0] lim;
	always_comb begin
		case (tk.sel)
			3'h0: lim = 12'h000;
			3'h1: lim = 12'h003;
			3'h2: lim = 12'h00F;
			3'h3: lim = 12'h01F;
			3'h4: lim = 12'h03F;
			3'h5: lim = 12'h0FF;
			3'h6: lim = 12'h3FF;
			default: lim = 12'hFFF;
		endcase
	end
	// Divider clears while stopped so a restart gives a full first period
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			pre_reg <= '0;
		end else if (!tk.run || pre_reg >= lim) begin
			pre_reg <= '0;
		end else begin
			pre_reg <= pre_reg + 12'h001;
		end
	end
	assign tk.tick = tk.run && (pre_reg >= lim);
	a_tick_div1: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(tk.run && tk.sel == 3'h0) |-> tk.tick)
		else $error("divide by one does not tick every cycle");
	a_tick_div4: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(tk.tick && tk.sel == 3'h1) ##1 (tk.run && tk.sel == 3'h1)
		|-> !tk.tick)
		else $error("divide by four spacing wrong");
	a_tick_spacing: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(tk.tick && tk.sel == 3'h1) ##1 (tk.run && tk.sel == 3'h1) [*4]
		|-> ##0 tk.tick)
		else $error("divide by four tick missing");
endmodule // wdt_prescaler

//--- hdl/wdt_core.sv
// Watchdog and interval timer: 8-bit counter, keyed counter and control writes,
// reset pulse generation and an interval interrupt.
// Assumes a simple one-cycle register port on the core clock.
`timescale 1ns/1ps
module wdt_core (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// Register port
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	// Interrupt to the interrupt controller
	output logic o_irq,
	output logic o_interval_irq,
	// Reset requests and pins
	output logic o_poweron_rst,
	output logic o_manual_rst,
	output logic o_reset_out_pin_n,
	output logic o_state_out_pin_0,
	output logic o_state_out_pin_1
);
	import wdt_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_POWERON, ST_MANUAL} rst_state_e;

	wdt_tick_if tk ();
	wdt_prescaler u_pre (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.tk(tk)
	);

	logic [7:0] wd_counter_reg;
	logic [7:0] wd_ctrl_status_reg;
	logic [1:0] irq_status_reg;
	logic [1:0] irq_mask_reg;
	logic [15:0] rdata_reg;
	logic [3:0] pulse_cnt_reg;
	rst_state_e rst_state_reg;
	logic wr_cnt_ok;
	logic wr_ctrl_ok;
	logic overflow;
	logic wd_ovf_evt;
	logic it_ovf_evt;

	wire timer_run_bit = wd_ctrl_status_reg[BIT_RUN];
	wire wd_or_interval_select = wd_ctrl_status_reg[BIT_MODE];
	wire reset_kind_select = wd_ctrl_status_reg[BIT_RST_KIND];

	// Byte or wrong-key writes are dropped silently
	assign wr_cnt_ok = i_wr && i_addr == ADDR_COUNTER &&
		i_wdata[15:8] == KEY_COUNTER;
	assign wr_ctrl_ok = i_wr && i_addr == ADDR_CTRL &&
		i_wdata[15:8] == KEY_CTRL;

	assign tk.run = timer_run_bit;
	assign tk.sel = wd_ctrl_status_reg[2:0];

	assign overflow = tk.tick && wd_counter_reg == COUNT_MAX;
	assign wd_ovf_evt = overflow && wd_or_interval_select;
	assign it_ovf_evt = overflow && !wd_or_interval_select;

	// A tick coinciding with a software write loses to the write
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			wd_counter_reg <= '0;
		end else if (wr_cnt_ok) begin
			wd_counter_reg <= i_wdata[7:0];
		end else if (tk.tick) begin
			wd_counter_reg <= wd_counter_reg + 8'h01;
		end
	end

	// Flags: hardware set wins over a software write of zero
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			wd_ctrl_status_reg <= CTRL_RESET;
		end else begin
			if (wr_ctrl_ok) begin
				wd_ctrl_status_reg <= i_wdata[7:0];
			end
			if (wd_ovf_evt) begin
				wd_ctrl_status_reg[BIT_WD_OVF] <= 1'b1;
			end
			if (it_ovf_evt) begin
				wd_ctrl_status_reg[BIT_IT_OVF] <= 1'b1;
			end
		end
	end

	// Reset pulse; kind only matters in watchdog mode
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rst_state_reg <= ST_IDLE;
			pulse_cnt_reg <= '0;
		end else begin
			case (rst_state_reg)
				ST_IDLE: begin
					if (wd_ovf_evt) begin
						rst_state_reg <= reset_kind_select ?
							ST_MANUAL : ST_POWERON;
						pulse_cnt_reg <= 4'(MANUAL_PULSE_CYCLES - 1);
					end
				end
				ST_POWERON: begin
					if (tk.tick) begin
						rst_state_reg <= ST_IDLE;
					end
				end
				ST_MANUAL: begin
					if (pulse_cnt_reg == 4'h0) begin
						rst_state_reg <= ST_IDLE;
					end else begin
						pulse_cnt_reg <= pulse_cnt_reg - 4'h1;
					end
				end
				default: rst_state_reg <= ST_IDLE;
			endcase
		end
	end

	wire rst_active = rst_state_reg != ST_IDLE;
	assign o_poweron_rst = rst_state_reg == ST_POWERON;
	assign o_manual_rst = rst_state_reg == ST_MANUAL;
	assign o_reset_out_pin_n = !rst_active;
	assign o_state_out_pin_0 = rst_active;
	assign o_state_out_pin_1 = rst_active;
	assign o_interval_irq = wd_ctrl_status_reg[BIT_IT_OVF] &&
		!wd_or_interval_select;

	// Sticky interrupt status, write one to clear; set wins
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			irq_status_reg <= IRQ_ZERO;
		end else begin
			for (int k = 0; k < 2; k++) begin
				if ((k == IRQ_WD && wd_ovf_evt) ||
					(k == IRQ_IT && it_ovf_evt)) begin
					irq_status_reg[k] <= 1'b1;
				end else if (i_wr && i_addr == ADDR_IRQ_STATUS &&
					i_wdata[k]) begin
					irq_status_reg[k] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			irq_mask_reg <= IRQ_ZERO;
		end else if (i_wr && i_addr == ADDR_IRQ_MASK) begin
			irq_mask_reg <= i_wdata[1:0];
		end
	end

	assign o_irq = |(irq_status_reg & irq_mask_reg);

	// Read data one cycle after the strobe, zero otherwise
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_reg <= '0;
		end else if (i_rd) begin
			case (i_addr)
				ADDR_COUNTER: rdata_reg <= {8'h00, wd_counter_reg};
				ADDR_CTRL: rdata_reg <= {8'h00, wd_ctrl_status_reg};
				ADDR_IRQ_STATUS: rdata_reg <= {14'h0000, irq_status_reg};
				ADDR_IRQ_MASK: rdata_reg <= {14'h0000, irq_mask_reg};
				default: rdata_reg <= '0;
			endcase
		end else begin
			rdata_reg <= '0;
		end
	end
	assign o_rdata = rdata_reg;

	a_wd_flag_set: assert property (@(posedge i_core_clk) disable iff (i_rst)
		wd_ovf_evt |=> wd_ctrl_status_reg[BIT_WD_OVF])
		else $error("watchdog flag not set on overflow");
	a_reset_starts: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(wd_ovf_evt && !rst_active) |=> !o_reset_out_pin_n)
		else $error("no reset after watchdog overflow");
	a_wrap_counts: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(overflow && !wr_cnt_ok) |=> wd_counter_reg == 8'h00)
		else $error("counter did not wrap to zero");
	a_pins_agree: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!o_reset_out_pin_n |-> (o_state_out_pin_0 && o_state_out_pin_1))
		else $error("state pins not high during reset");
	a_manual_len: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$rose(o_manual_rst) |-> o_manual_rst [*5] ##1 !o_manual_rst)
		else $error("manual reset pulse not five cycles");
	a_it_flag_set: assert property (@(posedge i_core_clk) disable iff (i_rst)
		it_ovf_evt |=> (wd_ctrl_status_reg[BIT_IT_OVF] && o_interval_irq))
		else $error("interval flag or request missing");
	a_kind_select: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(wd_ovf_evt && !rst_active && reset_kind_select) |=> o_manual_rst)
		else $error("manual reset not chosen");
	a_it_no_wdflag: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(it_ovf_evt && !wr_ctrl_ok) |=> !$rose(wd_ctrl_status_reg[BIT_WD_OVF]))
		else $error("watchdog flag set in interval mode");
	a_key_guard: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_wr && i_addr == ADDR_CTRL && i_wdata[15:8] != KEY_CTRL &&
		!overflow) |=> $stable(wd_ctrl_status_reg))
		else $error("unkeyed control write took effect");
	a_run_counts: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(tk.tick && !wr_cnt_ok) |=> wd_counter_reg == $past(wd_counter_reg)
		+ 8'h01)
		else $error("counter did not advance on tick");
endmodule // wdt_core

//--- testbench/wdt_sys_model.sv
// Model of the chip reset logic and interrupt controller around the timer.
// Assumes it samples the timer outputs on the core clock.
`timescale 1ns/1ps
module wdt_sys_model (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// Timer outputs
	input wire logic i_reset_out_pin_n,
	input wire logic i_state_out_pin_0,
	input wire logic i_state_out_pin_1,
	input wire logic i_interval_irq,
	// Observations
	output int o_rst_width,
	output int o_pin_errs,
	output int o_irq_count
);
	int run_len;
	logic irq_q;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			run_len <= 0;
			o_rst_width <= 0;
			o_pin_errs <= 0;
			o_irq_count <= 0;
			irq_q <= 1'b0;
		end else begin
			// Pulse width kept only when the pulse ends
			if (i_reset_out_pin_n !== 1'b1) begin
				run_len <= run_len + 1;
			end else if (run_len != 0) begin
				o_rst_width <= run_len;
				run_len <= 0;
			end
			if (i_reset_out_pin_n === 1'b0 && !(i_state_out_pin_0 === 1'b1 &&
					i_state_out_pin_1 === 1'b1)) begin
				o_pin_errs <= o_pin_errs + 1;
			end
			irq_q <= i_interval_irq;
			if (i_interval_irq === 1'b1 && irq_q !== 1'b1) begin
				o_irq_count <= o_irq_count + 1;
			end
		end
	end
endmodule // wdt_sys_model

//--- testbench/testbench.sv
// Self-checking bench for the watchdog and interval timer.
// Assumes the timer core holds its own prescaler.
`timescale 1ns/1ps
module testbench;
	import wdt_pkg::*;
	logic i_core_clk, i_rst, i_wr, i_rd, o_irq, o_interval_irq;
	logic o_poweron_rst, o_manual_rst, o_reset_out_pin_n, pin0, pin1;
	logic [3:0] i_addr;
	logic [15:0] i_wdata, o_rdata, d;
	int n_fail, checks_done, cyc, width, perrs, nirq;
	wdt_core DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_irq(o_irq), .o_interval_irq(o_interval_irq),
		.o_poweron_rst(o_poweron_rst), .o_manual_rst(o_manual_rst),
		.o_reset_out_pin_n(o_reset_out_pin_n), .o_state_out_pin_0(pin0),
		.o_state_out_pin_1(pin1));
	wdt_sys_model partner (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_reset_out_pin_n(o_reset_out_pin_n), .i_state_out_pin_0(pin0),
		.i_state_out_pin_1(pin1), .i_interval_irq(o_interval_irq),
		.o_rst_width(width), .o_pin_errs(perrs), .o_irq_count(nirq));
	task automatic give_verdict();
		$display("checks=%0d mismatches=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
			n_fail++;
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
		// Let the write settle before any output is looked at
		#1;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	task automatic t_reset_and_keys();
		rd(ADDR_CTRL);
		chk(d, 16'h0000);
		rd(4'h2);
		chk(d, 16'h0000);
		chk(o_reset_out_pin_n, 1'b1);
		wr(ADDR_COUNTER, 16'h0012);
		rd(ADDR_COUNTER);
		chk(d, 16'h0000);
		wr(ADDR_COUNTER, 16'h5A12);
		rd(ADDR_COUNTER);
		chk(d, 16'h0012);
	endtask
	task automatic t_dividers();
		int r;
		for (int k = 0; k < 8; k++) begin
			r = (k < 3) ? (1 << (2 * k)) : (k == 3) ? 32 : (64 << (2 * (k - 4)));
			wr(ADDR_CTRL, 16'hA500);
			wr(ADDR_COUNTER, 16'h5A00);
			wr(ADDR_CTRL, 16'hA580 | 16'(k));
			repeat (8 * r - 2) @(posedge i_core_clk);
			rd(ADDR_COUNTER);
			chk(d >= 16'h6 && d <= 16'hA, 1'b1);
		end
		wr(ADDR_CTRL, 16'hA500);
	endtask
	task automatic t_interval();
		// Reset kind set on purpose: interval mode must ignore it
		wr(ADDR_IRQ_MASK, 16'h0003);
		wr(ADDR_COUNTER, 16'h5AFD);
		wr(ADDR_CTRL, 16'hA5A0);
		repeat (10) @(posedge i_core_clk);
		chk(o_interval_irq, 1'b1);
		chk(o_reset_out_pin_n, 1'b1);
		chk(nirq, 1);
		rd(ADDR_COUNTER);
		chk(d >= 16'h6 && d <= 16'h10, 1'b1);
		rd(ADDR_CTRL);
		chk(d, 16'h00A8);
		rd(ADDR_IRQ_STATUS);
		chk(d, 16'h0002);
		chk(o_irq, 1'b1);
		wr(ADDR_IRQ_MASK, 16'h0001);
		chk(o_irq, 1'b0);
		wr(ADDR_IRQ_MASK, 16'h0002);
		chk(o_irq, 1'b1);
		wr(ADDR_IRQ_STATUS, 16'h0002);
		chk(o_irq, 1'b0);
		wr(ADDR_CTRL, 16'hA500);
	endtask
	task automatic t_kick();
		wr(ADDR_COUNTER, 16'h5AF0);
		wr(ADDR_CTRL, 16'hA5C0);
		repeat (4) begin
			repeat (8) @(posedge i_core_clk);
			wr(ADDR_COUNTER, 16'h5A00);
		end
		rd(ADDR_CTRL);
		chk(d, 16'h00C0);
		chk(o_reset_out_pin_n, 1'b1);
		wr(ADDR_CTRL, 16'hA500);
	endtask
	task automatic t_watchdog(input logic [7:0] c, input int lo, input int hi);
		wr(ADDR_COUNTER, 16'h5AFE);
		wr(ADDR_CTRL, {KEY_CTRL, c});
		for (int i = 0; i < 30 && o_reset_out_pin_n; i++) begin
			@(posedge i_core_clk);
		end
		#1;
		chk({o_manual_rst, o_poweron_rst}, c[5] ? 2'b10 : 2'b01);
		repeat (30) @(posedge i_core_clk);
		chk(width >= lo && width <= hi, 1'b1);
		chk(perrs, 0);
		rd(ADDR_CTRL);
		chk(d, {8'h00, c | 8'h10});
		wr(ADDR_CTRL, 16'hA500);
		wr(ADDR_IRQ_STATUS, 16'h0003);
	endtask
	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end
	always @(posedge i_core_clk) begin
		cyc++;
		if (cyc == 90000) begin
			n_fail++;
			give_verdict();
		end
	end
	initial begin
		i_rst = 1'b1;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 4'h0;
		i_wdata = 16'h0000;
		repeat (4) @(posedge i_core_clk);
		i_rst <= 1'b0;
		t_reset_and_keys();
		t_dividers();
		t_interval();
		t_kick();
		t_watchdog(8'hE0, 5, 5);
		t_watchdog(8'hC1, 3, 4);
		give_verdict();
	end
endmodule // testbench
